// ===== verilog/tbc_card_fsm.sv
`timescale 1ns/1ps
// Operation
// - Field on: leave power-off into idle, mute
// - Idle single-slot request: reply ATQB, declared
// - Multi-slot: random slot, slot one replies
// - Bad CRC frame: mute, state kept
// - Idle ignores halt, attrib, marker, block, deselect
// - Wrong AFI request: mute, back to idle
// - Foreign PUPI halt or attrib ignored
// - Matching slot marker replies ATQB, declared
// - Ready single-slot request: ATQB, declared
// - Ready multi-slot request draws new slot
// - Requested ignores halt, attrib, block, deselect
// - Declared own halt: acknowledge, enter halt
// - Declared own attrib: ATA, enter protocol
// - Declared ignores marker, block, deselect
// - Protocol block goes to layer, answer sent
// - Halt: mute on request, wake-up replies
// - Multi-slot and marker support is optional
// - Protocol mute on all activation commands
// - Protocol deselect: reply deselect, enter halt
module tbc_card_fsm
	import tbc_pkg::*;
#(
	parameter logic [31:0] OWN_PUPI = 32'h1234_5678, // Arbitrary value
	parameter logic [7:0] OWN_AFI = 8'h10, // Application family
	parameter logic [31:0] APP_DATA = 32'h0000_0000, // ATQB application data
	parameter logic [23:0] PROT_INFO = 24'h00_0000, // ATQB protocol info
	parameter bit MULTI_SLOT = 1'b1, // Multi-slot and marker support
	parameter int MAX_LEN = 16 // Frame buffer bytes
) (
	input wire logic clk, // System clock, 25 MHz
	input wire logic reset_n, // Async reset, active low
	input wire logic field_on, // RF field present pin
	input wire logic rf_clk, // Link bit clock pin
	input wire logic rf_rx_frame, // Received frame envelope pin
	input wire logic rf_rx_bit, // Received serial data pin
	output logic rf_tx_frame, // Reply frame envelope
	output logic rf_tx_bit, // Reply serial data
	output logic bp_out_valid, // Block to layer valid
	input wire logic bp_out_ready, // Layer takes byte
	output logic [7:0] bp_out_data, // Block byte to layer
	output logic bp_out_last, // Final block byte
	input wire logic bp_in_valid, // Layer answer valid
	output logic bp_in_ready, // Answer byte taken
	input wire logic [7:0] bp_in_data, // Layer answer byte
	input wire logic bp_in_last, // Final answer byte
	output tbc_state_t card_state // Current activation state
);
	localparam int IW = $clog2(MAX_LEN);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] fsync; // Field pin sync
		tbc_state_t st; // Activation state
		tbc_phase_t ph; // Frame engine phase
		tbc_rsp_t rsp; // Reply being sent
		logic [MAX_LEN-1:0][7:0] fbuf; // Received frame
		logic [IW:0] len; // Bytes stored
		logic ovf; // Frame too long
		logic [3:0] slot; // Chosen slot, 0 is slot one
		logic [15:0] lfsr; // Free-running random source
		logic [IW:0] idx; // Send or forward index
		logic [7:0] fdat; // Byte offered to layer
	} tbc_fsm_t;

	tbc_fsm_t r_r;
	tbc_fsm_t r_nxt;
	logic link_rise; // Link clock rise pulse

	tbc_byte_if rx_if ();
	tbc_byte_if tx_if ();

	// ----------------------------------------------------------------
	// Link ends
	// ----------------------------------------------------------------
	tbc_link_rx u_rx (
		.clk(clk),
		.reset_n(reset_n),
		.rf_clk(rf_clk),
		.rf_rx_frame(rf_rx_frame),
		.rf_rx_bit(rf_rx_bit),
		.link_rise(link_rise),
		.rx(rx_if.src)
	);

	tbc_link_tx u_tx (
		.clk(clk),
		.reset_n(reset_n),
		.link_rise(link_rise),
		.tx(tx_if.snk),
		.rf_tx_frame(rf_tx_frame),
		.rf_tx_bit(rf_tx_bit)
	);

	// Receiver has no back-pressure
	assign rx_if.ready = 1'b1;
	assign tx_if.ok = 1'b0;

	// Reply byte by kind and position
	function automatic logic [7:0] rsp_byte(input tbc_rsp_t k, input logic [IW:0] i);
		logic [95:0] atqb;
		atqb = {`TBC_ATQB_HDR, OWN_PUPI, APP_DATA, PROT_INFO};
		unique case (k)
			RSP_ATQB: rsp_byte = atqb[95 - 8 * int'(i) -: 8];
			RSP_HLT_ACK: rsp_byte = `TBC_HLT_ACK;
			RSP_ATA: rsp_byte = `TBC_ATA_BYTE;
			RSP_DESEL: rsp_byte = `TBC_PCB_DESEL;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic crc_ok, is_req, is_wup, is_slm, is_hlt, is_att, is_ibk, is_des;
		logic afi_ok, pupi_ok, n_ok, rlast;
		logic [IW:0] plen;
		logic [7:0] c0, afi;
		logic [3:0] mask, draw;
		crc_ok = 1'b0;
		is_req = 1'b0;
		is_wup = 1'b0;
		is_slm = 1'b0;
		is_hlt = 1'b0;
		is_att = 1'b0;
		is_ibk = 1'b0;
		is_des = 1'b0;
		afi_ok = 1'b0;
		pupi_ok = 1'b0;
		n_ok = 1'b0;
		rlast = 1'b0;
		plen = r_r.len - (IW+1)'(`TBC_CRC_LEN);
		c0 = r_r.fbuf[0];
		afi = r_r.fbuf[1];
		mask = 4'h0;
		draw = 4'h0;
		r_nxt = r_r;
		r_nxt.fsync = {r_r.fsync[0], field_on};
		r_nxt.lfsr = {r_r.lfsr[14:0], r_r.lfsr[15] ^ r_r.lfsr[13] ^ r_r.lfsr[12] ^ r_r.lfsr[10]};
		tx_if.valid = 1'b0;
		tx_if.data = 8'h00;
		tx_if.last = 1'b0;
		bp_out_valid = 1'b0;
		bp_in_ready = 1'b0;

		// Frame classification
		crc_ok = !r_r.ovf && (r_r.len > (IW+1)'(`TBC_CRC_LEN)) && rx_if.ok;
		is_req = (plen == (IW+1)'(`TBC_REQ_LEN)) && (c0 == `TBC_CMD_APF);
		is_wup = r_r.fbuf[2][`TBC_WUP_BIT];
		is_slm = MULTI_SLOT && (plen == (IW+1)'(1)) && (c0[3:0] == `TBC_SLOTM_NIB)
			&& (c0[7:4] != 4'h0);
		is_hlt = (plen == (IW+1)'(`TBC_HLTB_LEN)) && (c0 == `TBC_CMD_HLTB);
		is_att = (plen >= (IW+1)'(`TBC_ATTRIB_LEN)) && (c0 == `TBC_CMD_ATTRIB);
		is_ibk = (c0[7:5] == 3'h0) && c0[1];
		is_des = (plen == (IW+1)'(1)) && (c0 == `TBC_PCB_DESEL);
		afi_ok = (afi == 8'h00) || (afi == OWN_AFI)
			|| ((afi[3:0] == 4'h0) && (afi[7:4] == OWN_AFI[7:4]));
		pupi_ok = {r_r.fbuf[1], r_r.fbuf[2], r_r.fbuf[3], r_r.fbuf[4]} == OWN_PUPI;
		n_ok = r_r.fbuf[2][2:0] <= `TBC_NCODE_MAX;
		if (MULTI_SLOT) begin
			mask = 4'((5'h1 << r_r.fbuf[2][2:0]) - 5'h1);
		end
		draw = r_r.lfsr[3:0] & mask;

		if (!r_r.fsync[1]) begin
			r_nxt.st = ST_POWER_OFF;
			r_nxt.ph = PH_RECV;
			r_nxt.len = '0;
			r_nxt.ovf = 1'b0;
			r_nxt.slot = 4'h0;
			r_nxt.idx = '0;
		end else begin
			unique case (r_r.ph)
				// Collect bytes, then act on the frame end
				PH_RECV: begin
					if (rx_if.valid && !rx_if.last) begin
						if (r_r.len < (IW+1)'(MAX_LEN)) begin
							r_nxt.fbuf[r_r.len[IW-1:0]] = rx_if.data;
							r_nxt.len = r_r.len + 1'b1;
						end else begin
							r_nxt.ovf = 1'b1;
						end
					end else if (rx_if.valid && rx_if.last) begin
						r_nxt.len = '0;
						r_nxt.ovf = 1'b0;
						r_nxt.idx = '0;
						if (crc_ok) begin
							unique case (r_r.st)
								ST_POWER_OFF: r_nxt.st = ST_IDLE;
								ST_IDLE, ST_READY_REQ, ST_READY_DECL, ST_HALT: begin
									if (is_req && (r_r.st != ST_HALT || is_wup)) begin
										if (!afi_ok) begin
											r_nxt.st = ST_IDLE;
										end else if (n_ok) begin
											r_nxt.slot = draw;
											if (draw == 4'h0) begin
												r_nxt.st = ST_READY_DECL;
												r_nxt.rsp = RSP_ATQB;
												r_nxt.ph = PH_SEND;
											end else begin
												r_nxt.st = ST_READY_REQ;
											end
										end
									end else if (r_r.st == ST_READY_REQ && is_slm
										&& c0[7:4] == r_r.slot) begin
										r_nxt.st = ST_READY_DECL;
										r_nxt.rsp = RSP_ATQB;
										r_nxt.ph = PH_SEND;
									end else if (r_r.st == ST_READY_DECL && is_hlt && pupi_ok) begin
										r_nxt.st = ST_HALT;
										r_nxt.rsp = RSP_HLT_ACK;
										r_nxt.ph = PH_SEND;
									end else if (r_r.st == ST_READY_DECL && is_att && pupi_ok) begin
										r_nxt.st = ST_PROTOCOL;
										r_nxt.rsp = RSP_ATA;
										r_nxt.ph = PH_SEND;
									end
								end
								ST_PROTOCOL: begin
									if (is_des) begin
										r_nxt.st = ST_HALT;
										r_nxt.rsp = RSP_DESEL;
										r_nxt.ph = PH_SEND;
									end else if (is_ibk && !is_req && !is_slm) begin
										r_nxt.fdat = r_r.fbuf[0];
										r_nxt.len = r_r.len;
										r_nxt.ph = PH_FWD;
									end
								end
							endcase
						end
					end
				end
				// Send a fixed reply
				PH_SEND: begin
					rlast = (r_r.rsp != RSP_ATQB) || (r_r.idx == (IW+1)'(`TBC_ATQB_LEN - 1));
					tx_if.valid = 1'b1;
					tx_if.data = rsp_byte(r_r.rsp, r_r.idx);
					tx_if.last = rlast;
					if (tx_if.ready) begin
						r_nxt.idx = r_r.idx + 1'b1;
						if (rlast) begin
							r_nxt.ph = PH_RECV;
							r_nxt.idx = '0;
						end
					end
				end
				PH_FWD: begin
					bp_out_valid = 1'b1;
					if (bp_out_ready) begin
						r_nxt.idx = r_r.idx + 1'b1;
						r_nxt.fdat = r_r.fbuf[r_nxt.idx[IW-1:0]];
						if (r_r.idx == plen - 1'b1) begin
							r_nxt.ph = PH_RELAY;
							r_nxt.idx = '0;
						end
					end
				end
				PH_RELAY: begin
					tx_if.valid = bp_in_valid;
					tx_if.data = bp_in_data;
					tx_if.last = bp_in_last;
					bp_in_ready = tx_if.ready;
					if (bp_in_valid && tx_if.ready && bp_in_last) begin
						r_nxt.ph = PH_RECV;
						r_nxt.len = '0;
					end
				end
			endcase
			if (r_r.st == ST_POWER_OFF) begin
				r_nxt.st = ST_IDLE;
			end
		end
	end

	// Registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_r <= '0;
			r_r.lfsr <= `TBC_LFSR_SEED;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign bp_out_data = r_r.fdat;
	assign bp_out_last = (r_r.idx == plen_out(r_r.len));
	assign card_state = r_r.st;

	// Index of the last payload byte
	function automatic logic [IW:0] plen_out(input logic [IW:0] n);
		return n - (IW+1)'(`TBC_CRC_LEN) - 1'b1;
	endfunction
endmodule // tbc_card_fsm

// ===== verilog/tbc_cfg.svh
`ifndef TBC_CFG_SVH
`define TBC_CFG_SVH

// ----------------------------------------------------------------
// Frame codes seen from the reader
// ----------------------------------------------------------------
`define TBC_CMD_APF 8'h05
`define TBC_CMD_HLTB 8'h50
`define TBC_CMD_ATTRIB 8'h1D
`define TBC_PCB_DESEL 8'hC2
`define TBC_SLOTM_NIB 4'h5
`define TBC_WUP_BIT 3
`define TBC_NCODE_MAX 3'h4

// ----------------------------------------------------------------
// Payload lengths in bytes, CRC excluded
// ----------------------------------------------------------------
`define TBC_REQ_LEN 3
`define TBC_HLTB_LEN 5
`define TBC_ATTRIB_LEN 9
`define TBC_CRC_LEN 2
`define TBC_ATQB_LEN 12

// ----------------------------------------------------------------
// Reply bytes
// ----------------------------------------------------------------
`define TBC_ATQB_HDR 8'h50
`define TBC_HLT_ACK 8'h00
`define TBC_ATA_BYTE 8'h00

// ----------------------------------------------------------------
// CRC and slot draw
// ----------------------------------------------------------------
`define TBC_CRC_INIT 16'hFFFF
`define TBC_CRC_POLY 16'h8408
`define TBC_CRC_RESIDUE 16'hF0B8
`define TBC_LFSR_SEED 16'hACE1

`endif

// ===== verilog/tbc_pkg.sv
package tbc_pkg;
`include "tbc_cfg.svh"

	// Activation states of the card
	typedef enum logic [2:0] {
		ST_POWER_OFF,
		ST_IDLE,
		ST_READY_REQ,
		ST_READY_DECL,
		ST_PROTOCOL,
		ST_HALT
	} tbc_state_t;

	// What the frame engine is doing
	typedef enum logic [1:0] {
		PH_RECV,
		PH_SEND,
		PH_FWD,
		PH_RELAY
	} tbc_phase_t;

	// Fixed reply kinds
	typedef enum logic [1:0] {
		RSP_ATQB,
		RSP_HLT_ACK,
		RSP_ATA,
		RSP_DESEL
	} tbc_rsp_t;

	// One byte through the reflected CRC, LSB first
	function automatic logic [15:0] tbc_crc_byte(input logic [15:0] crc, input logic [7:0] d);
		logic [15:0] c;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			if (c[0] ^ d[i]) begin
				c = (c >> 1) ^ `TBC_CRC_POLY;
			end else begin
				c = c >> 1;
			end
		end
		return c;
	endfunction

endpackage

// ===== verilog/tbc_byte_if.sv
`timescale 1ns/1ps
// Byte stream between the link ends and the state machine
interface tbc_byte_if;
	logic valid; // Byte or end marker present
	logic ready; // Sink takes it
	logic [7:0] data; // Byte value
	logic last; // Final byte (tx) or end-of-frame marker (rx)
	logic ok; // Frame CRC good, with rx end marker
	modport src (output valid, output data, output last, output ok, input ready);
	modport snk (input valid, input data, input last, input ok, output ready);
endinterface

// ===== verilog/tbc_link_rx.sv
`timescale 1ns/1ps
// Samples the reader's link, assembles bytes and checks CRC
module tbc_link_rx
	import tbc_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic reset_n, // Async reset, active low
	input wire logic rf_clk, // Link bit clock pin
	input wire logic rf_rx_frame, // Frame envelope pin
	input wire logic rf_rx_bit, // Serial data pin
	output logic link_rise, // One-cycle pulse per link clock rise
	tbc_byte_if.src rx // Received bytes and end marker
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] cs; // Link clock sync, bit 0 first
		logic [2:0] fs; // Envelope sync
		logic [1:0] ds; // Data sync
		logic [7:0] sh; // Bit shifter
		logic [2:0] bits; // Bits in shifter
		logic [15:0] crc; // Running CRC
		logic got; // At least one byte seen
		logic ov; // Output valid
		logic ol; // Output is end marker
		logic ok; // CRC verdict
		logic [7:0] od; // Output byte
	} tbc_rx_t;

	tbc_rx_t r_r;
	tbc_rx_t r_nxt;
	logic rise;

	assign rise = r_r.cs[1] & ~r_r.cs[2];

	// Next state
	always_comb begin
		r_nxt = r_r;
		r_nxt.cs = {r_r.cs[1:0], rf_clk};
		r_nxt.fs = {r_r.fs[1:0], rf_rx_frame};
		r_nxt.ds = {r_r.ds[0], rf_rx_bit};
		r_nxt.ov = 1'b0;
		r_nxt.ol = 1'b0;
		if (r_r.fs[1] & ~r_r.fs[2]) begin
			// Frame opens
			r_nxt.crc = `TBC_CRC_INIT;
			r_nxt.bits = 3'h0;
			r_nxt.got = 1'b0;
		end else if (~r_r.fs[1] & r_r.fs[2]) begin
			// Frame closes: whole bytes and the residue mean good
			r_nxt.ov = 1'b1;
			r_nxt.ol = 1'b1;
			r_nxt.ok = r_r.got && (r_r.bits == 3'h0) && (r_r.crc == `TBC_CRC_RESIDUE);
		end else if (rise && r_r.fs[1]) begin
			// Shift one bit, LSB first
			r_nxt.sh = {r_r.ds[1], r_r.sh[7:1]};
			r_nxt.bits = r_r.bits + 1'b1;
			if (r_r.bits == 3'h7) begin
				r_nxt.ov = 1'b1;
				r_nxt.od = {r_r.ds[1], r_r.sh[7:1]};
				r_nxt.crc = tbc_crc_byte(r_r.crc, {r_r.ds[1], r_r.sh[7:1]});
				r_nxt.got = 1'b1;
			end
		end
	end

	// Registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign link_rise = rise;
	assign rx.valid = r_r.ov;
	assign rx.last = r_r.ol;
	assign rx.data = r_r.od;
	assign rx.ok = r_r.ok;
endmodule // tbc_link_rx

// ===== verilog/tbc_link_tx.sv
`timescale 1ns/1ps
// Sends a reply frame on the link, appending CRC
module tbc_link_tx
	import tbc_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic reset_n, // Async reset, active low
	input wire logic link_rise, // Bit step pulse
	tbc_byte_if.snk tx, // Reply bytes
	output logic rf_tx_frame, // Frame envelope out
	output logic rf_tx_bit // Serial data out
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic act; // Frame in progress
		logic [7:0] sh; // Bit shifter
		logic [3:0] bits; // Bits left in shifter
		logic [1:0] stg; // 0 data, 1 crc low, 2 crc high, 3 closing
		logic [15:0] crc; // Running CRC
		logic ob; // Output bit
		logic fr; // Envelope, up from the first bit out
	} tbc_tx_t;

	tbc_tx_t r_r;
	tbc_tx_t r_nxt;
	logic take;

	assign tx.ready = (r_r.bits == 4'h0) && (r_r.stg == 2'h0);
	assign take = tx.valid && tx.ready;

	// Next state
	always_comb begin
		r_nxt = r_r;
		if (take) begin
			// Load a data byte
			if (!r_r.act) begin
				r_nxt.crc = tbc_crc_byte(`TBC_CRC_INIT, tx.data);
			end else begin
				r_nxt.crc = tbc_crc_byte(r_r.crc, tx.data);
			end
			r_nxt.act = 1'b1;
			r_nxt.sh = tx.data;
			r_nxt.bits = 4'h8;
			r_nxt.stg = tx.last ? 2'h1 : 2'h0;
		end else if (r_r.act && r_r.bits == 4'h0 && r_r.stg[0] != r_r.stg[1]) begin
			// CRC bytes load at once, so no bit slot is lost
			r_nxt.sh = r_r.stg[0] ? ~r_r.crc[7:0] : ~r_r.crc[15:8];
			r_nxt.bits = 4'h8;
			r_nxt.stg = r_r.stg + 2'h1;
		end else if (link_rise && r_r.act) begin
			if (r_r.bits != 4'h0) begin
				// Shift out LSB first
				r_nxt.ob = r_r.sh[0];
				r_nxt.fr = 1'b1;
				r_nxt.sh = {1'b0, r_r.sh[7:1]};
				r_nxt.bits = r_r.bits - 1'b1;
			end else if (r_r.stg == 2'h3) begin
				// CRC sent, close the frame
				r_nxt.act = 1'b0;
				r_nxt.fr = 1'b0;
				r_nxt.stg = 2'h0;
				r_nxt.ob = 1'b0;
			end
		end
	end

	// Registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign rf_tx_frame = r_r.fr;
	assign rf_tx_bit = r_r.ob;
endmodule // tbc_link_tx

// ===== tb/tbc_card_props.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checks of the card state machine
// ----------------------------------------------------------------
module tbc_card_props
	import tbc_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic reset_n, // Async reset, active low
	input wire logic field_on, // Field present
	input wire logic rf_rx_frame, // Reader envelope
	input wire logic rf_tx_frame, // Reply envelope
	input wire logic bp_out_valid, // Block byte to layer
	input wire logic bp_out_ready, // Layer takes byte
	input wire logic [7:0] bp_out_data, // Block byte
	input wire logic bp_in_ready, // Answer byte taken
	input tbc_state_t card_state // Activation state
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Field edges, long enough to pass the two-stage sync
	sequence s_field_up;
		!field_on ##1 field_on [*5];
	endsequence
	sequence s_field_down;
		field_on ##1 !field_on [*5];
	endsequence

	property p_wake;
		s_field_up |-> card_state == ST_IDLE && !rf_tx_frame;
	endproperty
	a_wake: assert property (p_wake) else $error("field on gave no mute idle");
	property p_field_loss;
		s_field_down |-> card_state == ST_POWER_OFF;
	endproperty
	a_field_loss: assert property (p_field_loss) else $error("field loss kept state");
	property p_off_quiet;
		card_state == ST_POWER_OFF |-> !rf_tx_frame && !bp_out_valid;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("activity while off");
	property p_frame_hold;
		rf_rx_frame [*8] |-> $stable(card_state);
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("state moved mid frame");
	property p_halt_entry;
		card_state == ST_HALT && $past(card_state) != ST_HALT
			|-> $past(card_state) inside {ST_READY_DECL, ST_PROTOCOL};
	endproperty
	a_halt_entry: assert property (p_halt_entry) else $error("bad way into halt");
	property p_prot_entry;
		card_state == ST_PROTOCOL && $past(card_state) != ST_PROTOCOL
			|-> $past(card_state) == ST_READY_DECL;
	endproperty
	a_prot_entry: assert property (p_prot_entry) else $error("bad way into protocol");
	property p_prot_exit;
		$past(card_state) == ST_PROTOCOL && card_state != ST_PROTOCOL
			|-> card_state inside {ST_HALT, ST_POWER_OFF};
	endproperty
	a_prot_exit: assert property (p_prot_exit) else $error("bad way out of protocol");
	property p_fwd_prot;
		bp_out_valid |-> card_state == ST_PROTOCOL;
	endproperty
	a_fwd_prot: assert property (p_fwd_prot) else $error("block forwarded outside protocol");
	property p_fwd_hold;
		bp_out_valid && !bp_out_ready |=> bp_out_valid && $stable(bp_out_data);
	endproperty
	a_fwd_hold: assert property (p_fwd_hold) else $error("block byte dropped");
	property p_relay_prot;
		bp_in_ready |-> card_state == ST_PROTOCOL;
	endproperty
	a_relay_prot: assert property (p_relay_prot) else $error("answer taken outside protocol");
endmodule // tbc_card_props

bind tbc_card_fsm tbc_card_props u_props (.clk, .reset_n, .field_on, .rf_rx_frame, .rf_tx_frame,
	.bp_out_valid, .bp_out_ready, .bp_out_data, .bp_in_ready, .card_state);

// ===== tb/tbc_reader_model.sv
`timescale 1ns/1ps
`include "tbc_cfg.svh"
// ----------------------------------------------------------------
// Reader on the far side of the link
// ----------------------------------------------------------------
module tbc_reader_model (
	output logic rf_clk, // Link clock, still between exchanges
	output logic rf_rx_frame, // Frame envelope to the card
	output logic rf_rx_bit, // Serial data to the card
	input wire logic rf_tx_frame, // Card reply envelope
	input wire logic rf_tx_bit // Card reply data
);
	logic [7:0] rb[16]; // Reply bytes
	int rn; // Reply byte count
	logic [15:0] rres; // CRC run over the whole reply
	initial begin
		rf_clk = 1'b0;
		rf_rx_frame = 1'b0;
		rf_rx_bit = 1'b1;
	end

	// CRC step, reflected polynomial, LSB first
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			c = (c[0] ^ d[i]) ? ((c >> 1) ^ `TBC_CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	// One link period; reply line sampled just before the rise
	task automatic period(output logic s, output logic f);
		#150;
		s = rf_tx_bit;
		f = rf_tx_frame;
		#10 rf_clk = 1'b1;
		#160 rf_clk = 1'b0;
	endtask

	// Send payload plus CRC, then clock until the reply ends or stays away
	task automatic xfer(input logic [71:0] v, input int n, input bit bad);
		logic [7:0] b[11];
		logic [7:0] sh;
		logic [15:0] c;
		logic s, f;
		int k;
		c = `TBC_CRC_INIT;
		for (int i = 0; i < n; i++) begin
			b[i] = v[8*(n-1-i) +: 8];
			c = crc_step(c, b[i]);
		end
		// Good frames carry the complement, low byte first
		c = bad ? c : ~c;
		b[n] = c[7:0];
		b[n+1] = c[15:8];
		rf_rx_frame = 1'b1;
		for (int i = 0; i < 8 * (n + 2); i++) begin
			rf_rx_bit = b[i/8][i%8];
			period(s, f);
		end
		#160 rf_rx_frame = 1'b0;
		// Released data line shows the inverse of its last bit
		rf_rx_bit = ~rf_rx_bit;
		rn = 0;
		k = 0;
		rres = `TBC_CRC_INIT;
		for (int w = 0; w < 200; w++) begin
			period(s, f);
			if (!f && (k > 0 || w > 12)) break;
			if (f) begin
				sh = {s, sh[7:1]};
				k++;
				if (k % 8 == 0 && rn < 16) begin
					rb[rn] = sh;
					rres = crc_step(rres, sh);
					rn++;
				end
			end
		end
	endtask
endmodule // tbc_reader_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "tbc_cfg.svh"
module tb_top;
	import tbc_pkg::*;
	localparam logic [31:0] PUPI = 32'h1234_5678; // Card identifier, arbitrary
	localparam logic [31:0] XPUP = 32'h0BAD_F00D; // Foreign identifier
	localparam logic [71:0] REQ1 = 72'h05_0000; // Request, one slot
	localparam logic [71:0] WUP1 = 72'h05_0008; // Wake-up, one slot
	localparam logic [71:0] REQ16 = 72'h05_0004; // Request, 16 slots
	localparam logic [71:0] WUP16 = 72'h05_000C; // Wake-up, 16 slots
	localparam logic [71:0] REQX = 72'h05_2000; // Request, other family
	localparam logic [71:0] WUPX = 72'h05_2008; // Wake-up, other family
	localparam logic [71:0] HLT = {32'h0, 8'h50, PUPI}; // Halt, own id
	localparam logic [71:0] HLTX = {32'h0, 8'h50, XPUP}; // Halt, foreign id
	localparam logic [71:0] ATT = {8'h1D, PUPI, 32'h0}; // Attrib, own id
	localparam logic [71:0] ATTX = {8'h1D, XPUP, 32'h0}; // Attrib, foreign id
	localparam logic [71:0] IBLK = 72'h025A; // Block with first_test_command
	localparam logic [71:0] DES = 72'hC2; // Deselect
	logic clk, reset_n, field_on, rf_clk, rf_rx_frame, rf_rx_bit, rf_tx_frame, rf_tx_bit;
	logic bp_out_valid, bp_out_last, bp_in_ready;
	logic bp_out_ready = 1'b0, bp_in_valid = 1'b0, bp_in_last = 1'b0;
	logic [7:0] bp_out_data, bp_in_data = 8'h00;
	tbc_state_t card_state; // Observed state
	int n_fail, tests_run, on, ai; // Counters, layer byte counts
	logic [7:0] ob[4]; // Bytes seen by the layer
	bit tk; // Answer byte taken at last edge
	bit [1:0] lb; // End flags of the latest two block bytes

	tbc_card_fsm #(.OWN_PUPI(PUPI), .OWN_AFI(8'h10)) dut (.clk, .reset_n, .field_on, .rf_clk,
		.rf_rx_frame, .rf_rx_bit, .rf_tx_frame, .rf_tx_bit, .bp_out_valid, .bp_out_ready,
		.bp_out_data, .bp_out_last, .bp_in_valid, .bp_in_ready, .bp_in_data, .bp_in_last,
		.card_state);
	tbc_reader_model rd (.rf_clk, .rf_rx_frame, .rf_rx_bit, .rf_tx_frame, .rf_tx_bit);

	// System clock, 40 ns
	always #20 clk = ~clk;

	// Layer: collect block bytes, note taken answer bytes
	always @(posedge clk) begin
		if (bp_out_valid && bp_out_ready) begin
			if (on < 4) ob[on] = bp_out_data;
			lb = {lb[0], bp_out_last};
			on++;
		end
		tk = bp_in_valid && bp_in_ready;
	end
	// Layer: stall every other cycle, answer with first_test_reply
	always @(negedge clk) begin
		bp_out_ready <= ~bp_out_ready;
		if (tk) ai++;
		bp_in_valid <= (on == 2) && (ai < 2);
		bp_in_data <= (ai == 0) ? 8'h02 : 8'hA5;
		bp_in_last <= (ai == 1);
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_st(input tbc_state_t e);
		tests_run++;
		if (card_state !== e) begin
			n_fail++;
			$display("wrong value at %0t ns: got %h expected %h", $time, card_state, e);
		end
	endtask
	// One exchange: reply length, first byte, reply CRC, next state
	task automatic ex(input logic [71:0] v, input int n, input bit bad, input int rl,
		input logic [7:0] r0, input tbc_state_t st);
		rd.xfer(v, n, bad);
		chk(16'(rd.rn), 16'(rl));
		if (rl > 0) begin
			chk({8'h00, rd.rb[0]}, {8'h00, r0});
			chk(rd.rres, `TBC_CRC_RESIDUE);
		end
		chk_st(st);
	endtask
	task automatic mu(input logic [71:0] v, input int n, input tbc_state_t st);
		ex(v, n, 1'b0, 0, 8'h00, st);
	endtask
	task automatic aq(input logic [71:0] v);
		ex(v, 3, 1'b0, `TBC_ATQB_LEN + `TBC_CRC_LEN, `TBC_ATQB_HDR, ST_READY_DECL);
		chk({rd.rb[1], rd.rb[2]}, PUPI[31:16]);
		chk({rd.rb[3], rd.rb[4]}, PUPI[15:0]);
	endtask
	function automatic logic [71:0] mk(input int n);
		return {64'h0, 4'(n - 1), 4'h5};
	endfunction
	// Multi-slot request, repeated at shifted times while slot one answers
	task automatic rr(input logic [71:0] v);
		for (int i = 0; i < 16; i++) begin
			#(40 * i + 40);
			rd.xfer(v, 3, 1'b0);
			if (rd.rn == 0) break;
			chk({8'h00, rd.rb[0]}, 16'h0050);
		end
		chk_st(ST_READY_REQ);
	endtask
	// Marker sweep; the card must answer exactly once
	task automatic sw();
		int h;
		h = 0;
		for (int n = 2; n <= 16; n++) begin
			rd.xfer(mk(n), 1, 1'b0);
			if (rd.rn != 0) h++;
		end
		chk(16'(h), 16'h0001);
		chk_st(ST_READY_DECL);
	endtask

	task automatic t_idle();
		@(negedge clk) field_on = 1'b1;
		repeat (8) @(negedge clk);
		chk_st(ST_IDLE);
		chk({15'h0, rf_tx_frame}, 16'h0000);
		ex(REQ1, 3, 1'b1, 0, 8'h00, ST_IDLE);
		ex(WUP1, 3, 1'b1, 0, 8'h00, ST_IDLE);
		mu(HLTX, 5, ST_IDLE);
		mu(ATT, 9, ST_IDLE);
		for (int n = 2; n <= 16; n++) mu(mk(n), 1, ST_IDLE);
		mu(IBLK, 2, ST_IDLE);
		mu(DES, 1, ST_IDLE);
		mu(REQX, 3, ST_IDLE);
		aq(REQ1);
	endtask
	task automatic t_req();
		rr(REQ16);
		ex(WUP1, 3, 1'b1, 0, 8'h00, ST_READY_REQ);
		mu(HLT, 5, ST_READY_REQ);
		mu(ATT, 9, ST_READY_REQ);
		mu(IBLK, 2, ST_READY_REQ);
		mu(DES, 1, ST_READY_REQ);
		sw();
		rr(WUP16);
		mu(WUPX, 3, ST_IDLE);
		rr(REQ16);
		aq(REQ1);
	endtask
	task automatic t_decl();
		mu(mk(5), 1, ST_READY_DECL);
		mu(IBLK, 2, ST_READY_DECL);
		mu(DES, 1, ST_READY_DECL);
		mu(HLTX, 5, ST_READY_DECL);
		mu(ATTX, 9, ST_READY_DECL);
		ex(REQ1, 3, 1'b1, 0, 8'h00, ST_READY_DECL);
		aq(WUP1);
		ex(HLT, 5, 1'b0, 3, `TBC_HLT_ACK, ST_HALT);
	endtask
	task automatic t_halt();
		mu(REQ1, 3, ST_HALT);
		aq(WUP1);
		ex(ATT, 9, 1'b0, 3, `TBC_ATA_BYTE, ST_PROTOCOL);
	endtask
	task automatic t_prot();
		mu(REQ1, 3, ST_PROTOCOL);
		mu(WUP1, 3, ST_PROTOCOL);
		mu(HLT, 5, ST_PROTOCOL);
		mu(ATT, 9, ST_PROTOCOL);
		mu(mk(16), 1, ST_PROTOCOL);
		ex(IBLK, 2, 1'b0, 4, 8'h02, ST_PROTOCOL);
		chk({8'h00, rd.rb[1]}, 16'h00A5);
		chk(16'(on), 16'h0002);
		chk({ob[0], ob[1]}, 16'h025A);
		chk({14'h0, lb}, 16'h0001);
		ex(DES, 1, 1'b0, 3, `TBC_PCB_DESEL, ST_HALT);
	endtask
	task automatic t_off();
		@(negedge clk) field_on = 1'b0;
		repeat (8) @(negedge clk);
		chk_st(ST_POWER_OFF);
		field_on = 1'b1;
		repeat (8) @(negedge clk);
		chk_st(ST_IDLE);
		mu(mk(2), 1, ST_IDLE);
		aq(REQ1);
	endtask

	task automatic complete_run();
		$display("tests_run %0d n_fail %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog, about three times the expected run
	initial begin
		#3_600_000;
		n_fail++;
		complete_run();
	end

	// Main sequence
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		field_on = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		t_idle();
		t_req();
		t_decl();
		t_halt();
		t_prot();
		t_off();
		complete_run();
	end
endmodule // tb_top
